//--- adc_channel_select_mask.sv
`timescale 1ns/10ps
//------------------------------------------------------------------------------
// Channel-selection mask register and the conversion sequencer it steers
//------------------------------------------------------------------------------
module adc_channel_select_mask
(
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // Byte register port from the frame decoder
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic [7:0]       o_reg_rdata,
  // Test configuration enables
  input  wire logic        i_stack_sum_monitor_enable,
  input  wire logic        i_negative_pump_monitor_enable,
  // Conversion command
  input  wire logic        i_cmd_start,
  output logic             o_busy,
  output logic             o_cmd_done,
  // Converter handshake
  output logic             o_conv_req,
  output logic [4:0]       o_conv_source,
  output logic             o_pump_meas_enable,
  input  wire logic        i_conv_done,
  input  wire logic [15:0] i_conv_data,
  // Result byte stream
  output logic             o_res_valid,
  output logic [7:0]       o_res_byte,
  input  wire logic        i_res_ready
);

  //----------------------------------------------------------------------------
  // Declarations
  //----------------------------------------------------------------------------
  logic [31:0]               conversion_channel_mask_r;
  logic [31:0]               run_mask_r;
  adc_mask_pkg::seq_state_t  state_r;
  logic [4:0]                idx_r;
  logic                      phase_r;
  logic [15:0]               first_r;
  logic [15:0]               word_r;
  logic                      load_r;
  logic                      ser_busy;
  logic [16:0]               stack_sum;
  logic                      is_ref;
  logic                      is_stack;
  logic                      sel_hit;

  //----------------------------------------------------------------------------
  // Helpers
  //----------------------------------------------------------------------------
  // Byte lane of the mask for a register address, MSB byte at lowest address
  function automatic logic [1:0] lane_of(input logic [7:0] addr);
    logic [7:0] rel;
    rel     = addr - adc_mask_pkg::MASK_BYTE3_ADDR;
    lane_of = 2'h3 - rel[1:0];
  endfunction

  function automatic logic in_range(input logic [7:0] addr);
    in_range = (addr >= adc_mask_pkg::MASK_BYTE3_ADDR) &&
               (addr <= adc_mask_pkg::MASK_BYTE0_ADDR);
  endfunction

  // Converter source for a mask bit; ground stands in for a disabled stack sum
  function automatic logic [4:0] source_of(input logic [4:0] bit_idx,
                                           input logic       second,
                                           input logic       stack_en);
    source_of = adc_mask_pkg::SRC_PUMP;
    if (bit_idx >= adc_mask_pkg::CELL_LSB_BIT)
      source_of = adc_mask_pkg::SRC_CELL1 + (bit_idx - adc_mask_pkg::CELL_LSB_BIT); // R2
    else if (bit_idx >= adc_mask_pkg::AUX_LSB_BIT)
      source_of = adc_mask_pkg::SRC_AUX_BASE + (bit_idx - adc_mask_pkg::AUX_LSB_BIT); // R3
    else
    begin
      case (bit_idx)
        adc_mask_pkg::LOGIC_T_BIT:  source_of = adc_mask_pkg::SRC_LOGIC_T;  // R4
        adc_mask_pkg::ANALOG_T_BIT: source_of = adc_mask_pkg::SRC_ANALOG_T; // R5
        adc_mask_pkg::CORE_BIT:     source_of = adc_mask_pkg::SRC_CORE;     // R6
        adc_mask_pkg::REF_BIT:      source_of = second ? adc_mask_pkg::SRC_GROUND
                                                       : adc_mask_pkg::SRC_REF45; // R8
        adc_mask_pkg::STACK_BIT:    source_of = stack_en ? adc_mask_pkg::SRC_STACK
                                                         : adc_mask_pkg::SRC_GROUND; // R10
        default:                    source_of = adc_mask_pkg::SRC_PUMP;     // R11
      endcase
    end
  endfunction

  //----------------------------------------------------------------------------
  // Mask register
  //----------------------------------------------------------------------------
  // Byte writes land at once, so a write earlier in the frame is seen by a
  // command later in the same frame; the value then holds until rewritten.
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      conversion_channel_mask_r <= adc_mask_pkg::MASK_RESET;
    else if (i_reg_wr && in_range(i_reg_addr))
      conversion_channel_mask_r[lane_of(i_reg_addr)*8 +: 8] <= i_reg_wdata; // R13 R14
  end

  // Registered read data; addresses outside the mask read as zero
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      o_reg_rdata <= 8'h00;
    else if (i_reg_rd)
      o_reg_rdata <= in_range(i_reg_addr) ?
                     conversion_channel_mask_r[lane_of(i_reg_addr)*8 +: 8] : 8'h00;
  end

  //----------------------------------------------------------------------------
  // Decode of the bit under the scan pointer
  //----------------------------------------------------------------------------
  // Reserved bits are skipped even if the host set them against the contract
  assign sel_hit   = run_mask_r[idx_r] &&
                     (idx_r != adc_mask_pkg::RSVD_HI_BIT) &&
                     (idx_r != adc_mask_pkg::RSVD_LO_BIT);   // R1 R7
  assign is_ref    = (idx_r == adc_mask_pkg::REF_BIT);
  assign is_stack  = (idx_r == adc_mask_pkg::STACK_BIT);
  assign stack_sum = {1'b0, first_r} + {1'b0, i_conv_data};

  //----------------------------------------------------------------------------
  // Sequencer: walks the mask from bit 31 down, one result per selected bit, two (reference, then ground) for bit 2
  //----------------------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_r    <= adc_mask_pkg::ST_IDLE;
      run_mask_r <= adc_mask_pkg::MASK_RESET;
      idx_r      <= adc_mask_pkg::TOP_BIT;
      phase_r    <= 1'b0;
      first_r    <= 16'h0000;
      word_r     <= 16'h0000;
      load_r     <= 1'b0;
      o_cmd_done <= 1'b0;
    end
    else
    begin
      load_r     <= 1'b0;
      o_cmd_done <= 1'b0;
      case (state_r)
        adc_mask_pkg::ST_IDLE:
        begin
          if (i_cmd_start)
          begin
            // Snapshot keeps a mid-command write from tearing the sequence
            run_mask_r <= conversion_channel_mask_r;               // R13
            idx_r      <= adc_mask_pkg::TOP_BIT;                    // R12
            phase_r    <= 1'b0;
            state_r    <= adc_mask_pkg::ST_SCAN;
          end
        end
        adc_mask_pkg::ST_SCAN:
        begin
          if (sel_hit)
            state_r <= adc_mask_pkg::ST_CONV;                       // R1
          else if (idx_r == 5'h00)
          begin
            o_cmd_done <= 1'b1;
            state_r    <= adc_mask_pkg::ST_IDLE;
          end
          else
            idx_r <= idx_r - 5'h01;                                 // R12
        end
        adc_mask_pkg::ST_CONV:
        begin
          if (i_conv_done)
          begin
            if (is_stack && !phase_r)
            begin
              first_r <= i_conv_data;                               // R9
              phase_r <= 1'b1;
            end
            else
            begin
              word_r  <= is_stack ? stack_sum[16:1] : i_conv_data;  // R9
              load_r  <= 1'b1;
              state_r <= adc_mask_pkg::ST_SEND;
            end
          end
        end
        adc_mask_pkg::ST_SEND:
        begin
          if (!load_r && !ser_busy)
          begin
            if (is_ref && !phase_r)
            begin
              // Back through the scan so the registered source picks up ground
              phase_r <= 1'b1;                                      // R8
              state_r <= adc_mask_pkg::ST_SCAN;
            end
            else if (idx_r == 5'h00)
            begin
              phase_r    <= 1'b0;
              o_cmd_done <= 1'b1;
              state_r    <= adc_mask_pkg::ST_IDLE;
            end
            else
            begin
              phase_r <= 1'b0;
              idx_r   <= idx_r - 5'h01;
              state_r <= adc_mask_pkg::ST_SCAN;
            end
          end
        end
        default:
          state_r <= adc_mask_pkg::ST_IDLE;
      endcase
    end
  end

  //----------------------------------------------------------------------------
  // Converter request outputs
  //----------------------------------------------------------------------------
  assign o_busy             = (state_r != adc_mask_pkg::ST_IDLE);
  assign o_conv_req         = (state_r == adc_mask_pkg::ST_CONV);
  assign o_pump_meas_enable = o_conv_req && (idx_r == adc_mask_pkg::PUMP_BIT) &&
                              i_negative_pump_monitor_enable;       // R11

  // Source code comes from a flop; it is loaded during the scan cycle, so
  // every conversion request starts with a settled code on the bus
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      o_conv_source <= adc_mask_pkg::SRC_CELL1;
    else
      o_conv_source <= source_of(idx_r, phase_r, i_stack_sum_monitor_enable); // R2 R3 R10
  end

  //----------------------------------------------------------------------------
  // Result serializer
  //----------------------------------------------------------------------------
  result_byte_serializer u_serializer
  (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_load  (load_r),
    .i_word  (word_r),
    .o_busy  (ser_busy),
    .o_valid (o_res_valid),
    .o_byte  (o_res_byte),
    .i_ready (i_res_ready)
  );

endmodule

//--- adc_mask_monitor.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Port checker for the mask sequencer
// ---------------------------------------------------------------
module adc_mask_monitor
(
  // Clock and reset
  input wire logic       i_clock,
  input wire logic       i_rst,
  // Command and converter
  input wire logic       i_cmd_start,
  input wire logic       o_busy,
  input wire logic       o_cmd_done,
  input wire logic       o_conv_req,
  input wire logic [4:0] o_conv_source,
  input wire logic       i_conv_done,
  input wire logic       o_pump_meas_enable,
  input wire logic       i_negative_pump_monitor_enable,
  input wire logic       i_stack_sum_monitor_enable,
  // Result stream
  input wire logic       o_res_valid,
  input wire logic [7:0] o_res_byte,
  input wire logic       i_res_ready
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  // Reference conversion ends; ground must follow once its bytes drain
  sequence s_ref_done;
    o_conv_req && o_conv_source == 5'h1b && i_conv_done;
  endsequence
  sequence s_gnd_req;
    o_conv_req && o_conv_source == 5'h1c;
  endsequence

  a_busy_on_start: assert property (!o_busy && i_cmd_start |=> o_busy)
    else $error("busy not raised after start");
  a_req_holds_src: assert property (o_conv_req && !i_conv_done |=>
    o_conv_req && $stable(o_conv_source))
    else $error("request dropped or source moved early");
  a_pump_gate: assert property (o_conv_req && o_conv_source == 5'h1e |->
    o_pump_meas_enable == i_negative_pump_monitor_enable)
    else $error("pump enable wrong");
  a_result_holds: assert property (o_res_valid && !i_res_ready |=>
    o_res_valid && $stable(o_res_byte))
    else $error("result byte not held");
  a_done_single: assert property (o_cmd_done |=> !o_cmd_done)
    else $error("done longer than one cycle");
  a_req_in_cmd: assert property (o_conv_req |-> o_busy)
    else $error("conversion outside command");
  a_stack_to_gnd: assert property (o_conv_req && !i_stack_sum_monitor_enable |->
    o_conv_source != 5'h1d)
    else $error("stack sum converted while disabled");
  a_ref_then_gnd: assert property (s_ref_done |-> ##[1:300] s_gnd_req)
    else $error("ground did not follow reference");
endmodule

bind adc_channel_select_mask adc_mask_monitor u_mon (.i_clock, .i_rst, .i_cmd_start, .o_busy,
  .o_cmd_done, .o_conv_req, .o_conv_source, .i_conv_done, .o_pump_meas_enable,
  .i_negative_pump_monitor_enable, .i_stack_sum_monitor_enable, .o_res_valid,
  .o_res_byte, .i_res_ready);

//--- adc_mask_pkg.sv
//------------------------------------------------------------------------------
// Constants for the channel-selection mask and its conversion sequencer
//------------------------------------------------------------------------------
// Summary of operation
// R1: Convert channel exactly when its mask bit set
// R2: Bits 31..16 select cells 16 down to 1
// R3: Bits 15..8 select auxiliary inputs 7..0
// R4: Bit 7 adds logic die temperature
// R5: Bit 6 adds analog die temperature
// R6: Bit 5 adds core 1.8 V supply
// R7: Host writes zero to bits 4 and 3
// R8: Bit 2 reports reference, then ground
// R9: Bit 1 converts stack sum twice, reports average
// R10: Stack sum disabled means ground is measured
// R11: Bit 0 selects pump monitor, separately enabled
// R12: Results MSB first, highest bit first, skip unselected
// R13: Mask written earlier in frame applies
// R14: Mask holds value until rewritten
package adc_mask_pkg;

  //----------------------------------------------------------------------------
  // Register map: four byte addresses, lowest address holds bits 31..24
  //----------------------------------------------------------------------------
  localparam logic [7:0]  MASK_BYTE3_ADDR = 8'h03;
  localparam logic [7:0]  MASK_BYTE0_ADDR = 8'h06;
  localparam logic [31:0] MASK_RESET      = 32'h0000_0000;

  //----------------------------------------------------------------------------
  // Field positions inside the mask
  //----------------------------------------------------------------------------
  localparam logic [4:0] CELL_LSB_BIT  = 5'h10;
  localparam logic [4:0] AUX_LSB_BIT   = 5'h08;
  localparam logic [4:0] LOGIC_T_BIT   = 5'h07;
  localparam logic [4:0] ANALOG_T_BIT  = 5'h06;
  localparam logic [4:0] CORE_BIT      = 5'h05;
  localparam logic [4:0] RSVD_HI_BIT   = 5'h04;
  localparam logic [4:0] RSVD_LO_BIT   = 5'h03;
  localparam logic [4:0] REF_BIT       = 5'h02;
  localparam logic [4:0] STACK_BIT     = 5'h01;
  localparam logic [4:0] PUMP_BIT      = 5'h00;
  localparam logic [4:0] TOP_BIT       = 5'h1f;

  //----------------------------------------------------------------------------
  // Converter source codes: 0..15 cells 1..16, 16..23 aux 0..7
  //----------------------------------------------------------------------------
  localparam logic [4:0] SRC_CELL1    = 5'h00;
  localparam logic [4:0] SRC_AUX_BASE = 5'h10;
  localparam logic [4:0] SRC_LOGIC_T  = 5'h18;
  localparam logic [4:0] SRC_ANALOG_T = 5'h19;
  localparam logic [4:0] SRC_CORE     = 5'h1a;
  localparam logic [4:0] SRC_REF45    = 5'h1b;
  localparam logic [4:0] SRC_GROUND   = 5'h1c;
  localparam logic [4:0] SRC_STACK    = 5'h1d;
  localparam logic [4:0] SRC_PUMP     = 5'h1e;

  //----------------------------------------------------------------------------
  // Sequencer states
  //----------------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SCAN = 4'h2,
    ST_CONV = 4'h4,
    ST_SEND = 4'h8
  } seq_state_t;

endpackage

//--- conv_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Converter model: fast or slow answer, distinct values per pass
// ---------------------------------------------------------------
module conv_model
(
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // Request side
  input  wire logic        i_conv_req,
  input  wire logic [4:0]  i_conv_source,
  input  wire logic        i_slow,
  // Answer side
  output logic             o_conv_done,
  output logic [15:0]      o_conv_data
);
  logic [2:0] cnt_r;
  logic [1:0] pass_r;

  // Second pass on one request reads 2 higher, so an average shows
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_r       <= 3'h0;
      pass_r      <= 2'h0;
      o_conv_done <= 1'b0;
      o_conv_data <= 16'h0000;
    end
    else
    begin
      o_conv_done <= 1'b0;
      o_conv_data <= ~o_conv_data; // Data only meaningful with done
      if (!i_conv_req)
      begin
        cnt_r  <= 3'h0;
        pass_r <= 2'h0;
      end
      else if (o_conv_done)
        cnt_r <= 3'h0;
      else if (cnt_r == (i_slow ? 3'h5 : 3'h1))
      begin
        o_conv_done <= 1'b1;
        o_conv_data <= {3'h0, i_conv_source, 8'h10} + {13'h0, pass_r, 1'b0};
        pass_r      <= pass_r + 2'h1;
        cnt_r       <= 3'h0;
      end
      else
        cnt_r <= cnt_r + 3'h1;
    end
  end
endmodule

//--- result_byte_serializer.sv
`timescale 1ns/10ps
//------------------------------------------------------------------------------
// Splits one 16-bit result into two bytes, most significant first
//------------------------------------------------------------------------------
module result_byte_serializer
(
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // Word side
  input  wire logic        i_load,
  input  wire logic [15:0] i_word,
  output logic             o_busy,
  // Byte side
  output logic             o_valid,
  output logic [7:0]       o_byte,
  input  wire logic        i_ready
);

  logic [7:0] low_r;
  logic       second_r;

  // Byte stream register; a load while busy is never issued by the sequencer
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_valid  <= 1'b0;
      o_byte   <= 8'h00;
      low_r    <= 8'h00;
      second_r <= 1'b0;
    end
    else if (i_load && !o_valid)
    begin
      o_valid  <= 1'b1;
      o_byte   <= i_word[15:8];                 // R12
      low_r    <= i_word[7:0];
      second_r <= 1'b0;
    end
    else if (o_valid && i_ready)
    begin
      o_valid  <= !second_r;
      o_byte   <= low_r;
      second_r <= 1'b1;
    end
  end

  assign o_busy = o_valid;

endmodule

//--- tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) \
  begin \
    checks++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("[ERR] %s exp=%h got=%h", nm, e, g); \
    end \
  end
// ---------------------------------------------------------------
// Bench for the channel mask and sequencer
// ---------------------------------------------------------------
module tb_top;
  logic        i_clock, i_rst, i_reg_wr, i_reg_rd, i_cmd_start, i_res_ready, slow, stall;
  logic        i_stack_sum_monitor_enable, i_negative_pump_monitor_enable, i_conv_done;
  logic        o_busy, o_cmd_done, o_conv_req, o_pump_meas_enable, o_res_valid;
  logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata, o_res_byte, rd;
  logic [4:0]  o_conv_source;
  logic [15:0] i_conv_data;
  logic [7:0]  exp_q[$], got_q[$];
  int          fail_count, checks;

  adc_channel_select_mask uut (.i_clock, .i_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr,
    .i_reg_wdata, .o_reg_rdata, .i_stack_sum_monitor_enable, .i_negative_pump_monitor_enable,
    .i_cmd_start, .o_busy, .o_cmd_done, .o_conv_req, .o_conv_source, .o_pump_meas_enable,
    .i_conv_done, .i_conv_data, .o_res_valid, .o_res_byte, .i_res_ready);
  conv_model u_conv (.i_clock, .i_rst, .i_conv_req(o_conv_req), .i_conv_source(o_conv_source),
    .i_slow(slow), .o_conv_done(i_conv_done), .o_conv_data(i_conv_data));

  always #10 i_clock = ~i_clock;
  // Stalling consumer accepts every other cycle
  always @(negedge i_clock) i_res_ready <= stall ? ~i_res_ready : 1'b1;
  always @(posedge i_clock) if (o_res_valid && i_res_ready) got_q.push_back(o_res_byte);

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clock);
    {i_reg_wr, i_reg_addr, i_reg_wdata} = {1'b1, a, d};
    @(negedge i_clock);
    i_reg_wr = 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clock);
    {i_reg_rd, i_reg_addr} = {1'b1, a};
    @(negedge i_clock);
    i_reg_rd = 1'b0;
    d = o_reg_rdata;
  endtask

  // Bits 4 and 3 are always written as zero by every caller
  task automatic set_mask(input logic [31:0] m);
    for (int i = 0; i < 4; i++) reg_wr(8'(3 + i), m[31 - 8 * i -: 8]);
  endtask

  function automatic void push(input logic [15:0] v);
    exp_q.push_back(v[15:8]);
    exp_q.push_back(v[7:0]);
  endfunction

  // Expected stream, highest mask bit first, two bytes per value
  function automatic void build(input logic [31:0] m);
    logic [4:0] s;
    for (int b = 31; b >= 0; b--)
    begin
      if (!m[b] || b == 4 || b == 3) continue;
      s = (b >= 16) ? 5'(b - 16) : (b >= 8) ? 5'(b + 8) :
          (b >= 5) ? 5'(31 - b) : (b == 2) ? 5'h1b : (b == 0) ? 5'h1e :
          (i_stack_sum_monitor_enable ? 5'h1d : 5'h1c);
      push({3'h0, s, 8'h10} + ((b == 1) ? 16'h0001 : 16'h0000));
      if (b == 2) push(16'h1c10);
    end
  endfunction

  task automatic run_cmd(input logic [31:0] m, input logic refuse);
    int n;
    exp_q.delete();
    got_q.delete();
    build(m);
    @(negedge i_clock);
    i_cmd_start = 1'b1;
    @(negedge i_clock);
    i_cmd_start = 1'b0;
    if (refuse)
    begin
      repeat (3) @(negedge i_clock);
      i_cmd_start = 1'b1; // Ignored while busy
      @(negedge i_clock);
      i_cmd_start = 1'b0;
    end
    n = 0;
    while (o_cmd_done !== 1'b1 && n < 4000)
    begin
      @(negedge i_clock);
      n++;
    end
    if (n == 4000)
    begin
      fail_count++;
      $display("[ERR] command done exp=1 got=0");
      print_verdict();
    end
    else
    begin
      repeat (3) @(negedge i_clock);
      `CHK("byte count", exp_q.size(), got_q.size())
      foreach (exp_q[i]) `CHK("result byte", exp_q[i], got_q[i])
    end
  endtask

  task automatic t_regs;
    set_mask(32'h1234_56e7);
    reg_wr(8'h07, 8'hff);
    for (int i = 0; i < 4; i++)
    begin
      reg_rd(8'(3 + i), rd);
      `CHK("mask byte", 8'({32'h1234_56e7} >> (24 - 8 * i)), rd)
    end
    reg_rd(8'h07, rd);
    `CHK("unmapped byte", 8'h00, rd)
    $display("Test registers done");
  endtask

  task automatic t_cells;
    {slow, stall} = 2'b11;
    set_mask(32'h8001_0000);
    run_cmd(32'h8001_0000, 1'b1);
    run_cmd(32'h8001_0000, 1'b0);
    $display("Test cells done");
  endtask

  task automatic t_misc;
    {slow, stall} = 2'b00;
    set_mask(32'h0000_81e0);
    run_cmd(32'h0000_81e0, 1'b0);
    set_mask(32'hffff_ffe7);
    run_cmd(32'hffff_ffe7, 1'b0);
    $display("Test aux and full done");
  endtask

  task automatic t_ref;
    {slow, stall} = 2'b01;
    {i_stack_sum_monitor_enable, i_negative_pump_monitor_enable} = 2'b11;
    set_mask(32'h0000_0007);
    run_cmd(32'h0000_0007, 1'b0);
    {i_stack_sum_monitor_enable, i_negative_pump_monitor_enable} = 2'b00;
    run_cmd(32'h0000_0007, 1'b0);
    $display("Test reference and monitors done");
  endtask

  initial
  begin
    {i_clock, i_rst, i_reg_wr, i_reg_rd, i_cmd_start} = 5'h08;
    {slow, stall, i_stack_sum_monitor_enable, i_negative_pump_monitor_enable} = 4'h3;
    {i_reg_addr, i_reg_wdata} = 16'h0000;
    fail_count = 0;
    checks = 0;
    repeat (12) @(posedge i_clock);
    @(negedge i_clock);
    i_rst = 1'b0;
    t_regs();
    t_cells();
    t_misc();
    t_ref();
    print_verdict();
  end
endmodule
